// ---- design/ces_params.svh ----
/*
 * Register offsets, field positions, reset values and fixed codes of the
 * exception sequencer.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef CES_PARAMS_SVH
`define CES_PARAMS_SVH

// ***************************************************************
// Register map (byte addresses on the bus)
// ***************************************************************
`define CES_REG_STATUS 8'h00
`define CES_REG_SSP 8'h04
`define CES_REG_VBR 8'h08
`define CES_REG_STATE 8'h0C
`define CES_REG_HPC 8'h10

// ***************************************************************
// Reset values
// ***************************************************************
`define CES_SR_RST 16'h0000
`define CES_SSP_RST 32'h00000000
`define CES_VBR_RST 32'h00000000

// ***************************************************************
// Status word fields
// ***************************************************************
`define CES_SR_T 15
`define CES_SR_S 13
`define CES_SR_M 12
`define CES_SR_IHI 10
`define CES_SR_ILO 8

// ***************************************************************
// Vector numbers and table layout
// ***************************************************************
`define CES_VEC_ACCESS 8'h02
`define CES_VEC_ADDRESS 8'h03
`define CES_VEC_ILLEGAL 8'h04
`define CES_VEC_DIVZERO 8'h05
`define CES_VEC_PRIV 8'h08
`define CES_VEC_TRACE 8'h09
`define CES_VEC_LINEA 8'h0A
`define CES_VEC_LINEF 8'h0B
`define CES_VEC_DEBUG 8'h0C
`define CES_VEC_FORMAT 8'h0E
`define CES_VEC_SPURIOUS 8'h18
`define CES_VEC_TRAP0 8'h20
`define CES_VBR_MASK 32'hFFF00000

// ***************************************************************
// Frame and acknowledge space
// ***************************************************************
`define CES_FMT_BASE 4'h4
`define CES_FRAME_BYTES 32'h00000008
`define CES_PUSH_BYTES 32'h00000004
`define CES_FS_NONE 4'h0
`define CES_INTERRUPT_ACK_CYCLE_BASE 32'hFFFFFFE0
`define CES_IRQ_EDGE_LVL 3'h7

`endif

// ---- design/ces_pkg.sv ----
/*
 * Types shared by the exception sequencer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ces_pkg;
    typedef enum logic [3:0] {
        CES_EXC_ACCESS, CES_EXC_ADDRESS, CES_EXC_ILLEGAL, CES_EXC_DIVZERO,
        CES_EXC_PRIV, CES_EXC_TRACE, CES_EXC_LINEA, CES_EXC_LINEF,
        CES_EXC_DEBUG, CES_EXC_FORMAT, CES_EXC_SPURIOUS, CES_EXC_TRAP,
        CES_EXC_IRQ
    } ces_exc_t;

    typedef enum logic [2:0] {
        CES_ST_IDLE, CES_ST_INTERRUPT_ACK_CYCLE, CES_ST_PUSH_PC, CES_ST_PUSH_FV,
        CES_ST_FETCH_VEC, CES_ST_FETCH_OP, CES_ST_PUSH_SR
    } ces_state_t;
endpackage

`default_nettype wire

// ---- design/ces_calc_if.sv ----
/*
 * Carrier between the sequencer and its frame calculator.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

interface ces_calc_if;
    import ces_pkg::*;
    ces_exc_t exc;
    logic [3:0] trap_num;
    logic [7:0] interrupt_ack_cycle_vec;
    logic [3:0] fs_in;
    logic [31:0] supervisor_stack_pointer;
    logic [31:0] vbr;
    logic [7:0] vec;
    logic [15:0] fv;
    logic [31:0] frame_lo;
    logic [31:0] vec_addr;
    logic use_fault;

    modport calc (input exc, trap_num, interrupt_ack_cycle_vec, fs_in, supervisor_stack_pointer, vbr,
                  output vec, fv, frame_lo, vec_addr, use_fault);
    modport seq (output exc, trap_num, interrupt_ack_cycle_vec, fs_in, supervisor_stack_pointer, vbr,
                 input vec, fv, frame_lo, vec_addr, use_fault);
endinterface

`default_nettype wire

// ---- design/ces_frame_calc.sv ----
/*
 * Vector number, format/vector word and frame addresses of one exception.
 * Assumes the sequencer holds its inputs stable during the exception.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ces_params.svh"

module ces_frame_calc (
    ces_calc_if.calc cif // Calculator side
);
    import ces_pkg::*;

    logic [3:0] fs;
    logic [3:0] fmt;

    always_comb begin
        cif.vec = `CES_VEC_ILLEGAL;
        cif.use_fault = 1'b0;
        case (cif.exc)
            CES_EXC_ACCESS: begin
                cif.vec = `CES_VEC_ACCESS;
                cif.use_fault = 1'b1;
            end
            CES_EXC_ADDRESS: begin
                cif.vec = `CES_VEC_ADDRESS;
                cif.use_fault = 1'b1;
            end
            CES_EXC_ILLEGAL: begin
                cif.vec = `CES_VEC_ILLEGAL;
                cif.use_fault = 1'b1;
            end
            CES_EXC_DIVZERO: begin
                cif.vec = `CES_VEC_DIVZERO;
                cif.use_fault = 1'b1;
            end
            CES_EXC_PRIV: begin
                cif.vec = `CES_VEC_PRIV;
                cif.use_fault = 1'b1;
            end
            CES_EXC_TRACE: cif.vec = `CES_VEC_TRACE;
            CES_EXC_LINEA: begin
                cif.vec = `CES_VEC_LINEA;
                cif.use_fault = 1'b1;
            end
            CES_EXC_LINEF: begin
                cif.vec = `CES_VEC_LINEF;
                cif.use_fault = 1'b1;
            end
            CES_EXC_DEBUG: cif.vec = `CES_VEC_DEBUG;
            CES_EXC_FORMAT: begin
                cif.vec = `CES_VEC_FORMAT;
                cif.use_fault = 1'b1;
            end
            CES_EXC_SPURIOUS: cif.vec = `CES_VEC_SPURIOUS;
            CES_EXC_TRAP: begin
                cif.vec = `CES_VEC_TRAP0 | {4'h0, cif.trap_num};
            end
            CES_EXC_IRQ: cif.vec = cif.interrupt_ack_cycle_vec;
            default: cif.vec = `CES_VEC_ILLEGAL;
        endcase
    end

    // Only access and address errors carry a fault status
    assign fs = (cif.exc == CES_EXC_ACCESS || cif.exc == CES_EXC_ADDRESS) ?
                cif.fs_in : `CES_FS_NONE;
    assign fmt = `CES_FMT_BASE + {2'b00, cif.supervisor_stack_pointer[1:0]};
    assign cif.fv = {fmt, fs[3:2], cif.vec, fs[1:0]};
    // Frame forced onto a longword boundary below the old pointer
    assign cif.frame_lo = {cif.supervisor_stack_pointer[31:2], 2'b00} - `CES_FRAME_BYTES;
    // Vector byte index is 4 x vector, within a 1024 byte table
    assign cif.vec_addr = (cif.vbr & `CES_VBR_MASK) |
                          {22'h0, cif.vec, 2'b00};
endmodule

`default_nettype wire

// ---- design/ces_exception_seq.sv ----
/*
 * Exception sequencer: status update, vector acquisition, frame push,
 * handler fetch, and the push-status-then-load instruction, with a
 * classic Wishbone slave for the status word, stack pointer and base.
 * Assumes one clock, synchronous core inputs, and a memory port that
 * holds each request until it answers with mem_ack_i.
 */
// What this block does
// - Copy status, set supervisor, clear trace
// - Interrupt clears master flag, loads mask level
// - Faults compute vector; interrupts run acknowledge
// - Acknowledge in own space, level in address
// - Fixed frame on longword-aligned stack address
// - Handler address at base plus four vector
// - Finish once first handler fetch starts
// - Table of 256 longword vectors, 1024 bytes
// - Fixed vector numbers per fault type
// - Traps use vectors 32-47, next PC
// - Faults stack faulting PC, others next PC
// - No interrupt sampling in first handler instruction
// - Lower longword format/vector and status, upper PC
// - Format is 4 plus pointer low bits
// - Fault status zero except access, address errors
// - Vector field internal or controller supplied
// - Push status word, then load immediate
// - Restartable: faulting instruction re-executes later
// - Mask holds off levels, edge level 7 passes
`timescale 1ns/10ps
`default_nettype none
`include "ces_params.svh"

module ces_exception_seq (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Bus write
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Bus acknowledge
    input wire logic exc_req_i, // Fault or trap request
    input wire ces_pkg::ces_exc_t exc_type_i, // Exception type
    input wire logic [3:0] trap_num_i, // Trap number
    input wire logic [3:0] fault_status_i, // Fault status
    input wire logic [31:0] fault_pc_i, // Faulting instruction
    input wire logic [31:0] next_pc_i, // Next instruction
    input wire logic instr_done_i, // Instruction retired
    input wire logic [2:0] irq_level_i, // Requested level
    input wire logic pushld_req_i, // Push-status-load instr
    input wire logic [15:0] pushld_imm_i, // Its immediate
    output logic busy_o, // Sequencing
    output logic handler_go_o, // First handler fetch
    output logic [31:0] handler_pc_o, // Handler address
    output logic [15:0] status_word_o, // Status word
    output logic [31:0] ssp_o, // Supervisor stack pointer
    output logic mem_req_o, // Memory request
    output logic mem_we_o, // Memory write
    output logic mem_ack_space_o, // Acknowledge space
    output logic [31:0] mem_adr_o, // Memory address
    output logic [31:0] mem_dat_o, // Memory write data
    input wire logic [31:0] mem_dat_i, // Memory read data
    input wire logic mem_ack_i // Memory answer
);
    import ces_pkg::*;

    // ***************************************************************
    // Frame calculator
    // ***************************************************************
    ces_calc_if cif ();
    ces_frame_calc u_calc (
        .cif(cif.calc)
    );

    ces_state_t state_r, state_nxt;
    ces_exc_t exc_r, exc_nxt;
    logic [15:0] sr_r, sr_nxt;
    logic [15:0] sr_copy_r, sr_copy_nxt;
    logic [31:0] ssp_r, ssp_nxt;
    logic [31:0] vbr_r, vbr_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic [31:0] hpc_r, hpc_nxt;
    logic [3:0] fs_r, fs_nxt;
    logic [3:0] trap_r, trap_nxt;
    logic [2:0] lvl_r, lvl_nxt;
    logic [7:0] vec_r, vec_nxt;
    logic inhibit_r, inhibit_nxt;
    logic nmi_r, nmi_nxt;
    logic lvl7_prev_r;
    logic idle;
    logic irq_ok;
    logic take_exc;
    logic take_irq;
    logic [2:0] take_lvl;
    logic wb_wr;
    logic [15:0] sr_taken;
    logic [31:0] sr_merged;

    // ***************************************************************
    // Interrupt recognition
    // ***************************************************************
    assign idle = (state_r == CES_ST_IDLE);
    // Faults outrank interrupts; the push instruction outranks both
    assign take_exc = idle && !pushld_req_i && exc_req_i;
    // Level 7 edge latch bypasses the mask
    assign irq_ok = (irq_level_i > sr_r[`CES_SR_IHI:`CES_SR_ILO]) ||
                    nmi_r;
    // Sampling blocked until the handler's first instruction retires
    assign take_irq = idle && !pushld_req_i && !exc_req_i && irq_ok &&
                      !inhibit_r;
    assign take_lvl = nmi_r ? `CES_IRQ_EDGE_LVL : irq_level_i;

    // Status as it stands once an exception is taken
    always_comb begin
        sr_taken = sr_r;
        sr_taken[`CES_SR_S] = 1'b1;
        sr_taken[`CES_SR_T] = 1'b0;
        if (take_irq) begin
            sr_taken[`CES_SR_M] = 1'b0;
            sr_taken[`CES_SR_IHI:`CES_SR_ILO] = take_lvl;
        end
    end

    assign cif.exc = idle ? (take_irq ? CES_EXC_IRQ : exc_type_i) : exc_r;
    assign cif.trap_num = idle ? trap_num_i : trap_r;
    assign cif.interrupt_ack_cycle_vec = vec_r;
    assign cif.fs_in = idle ? fault_status_i : fs_r;
    assign cif.supervisor_stack_pointer = ssp_r;
    assign cif.vbr = vbr_r;

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Writes land on the edge where the master sees ack
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign sr_merged = merge({16'h0, sr_r}, wb_dat_i, wb_sel_i);

    always_comb begin
        state_nxt = state_r;
        exc_nxt = exc_r;
        sr_nxt = sr_r;
        sr_copy_nxt = sr_copy_r;
        ssp_nxt = ssp_r;
        vbr_nxt = vbr_r;
        pc_nxt = pc_r;
        hpc_nxt = hpc_r;
        fs_nxt = fs_r;
        trap_nxt = trap_r;
        lvl_nxt = lvl_r;
        vec_nxt = vec_r;
        inhibit_nxt = inhibit_r;
        nmi_nxt = nmi_r;
        if (nmi_r && take_irq) begin
            nmi_nxt = 1'b0;
        end
        // A fresh edge wins over the clear in the same cycle
        if (irq_level_i == `CES_IRQ_EDGE_LVL && !lvl7_prev_r) begin
            nmi_nxt = 1'b1;
        end
        if (idle && instr_done_i) begin
            inhibit_nxt = 1'b0;
        end
        case (state_r)
            CES_ST_IDLE: begin
                // Software may write the registers only between exceptions
                if (wb_wr && wb_adr_i == `CES_REG_STATUS) begin
                    sr_nxt = sr_merged[15:0];
                end
                if (wb_wr && wb_adr_i == `CES_REG_SSP) begin
                    ssp_nxt = merge(ssp_r, wb_dat_i, wb_sel_i);
                end
                if (wb_wr && wb_adr_i == `CES_REG_VBR) begin
                    vbr_nxt = merge(vbr_r, wb_dat_i, wb_sel_i) &
                              `CES_VBR_MASK;
                end
                if (pushld_req_i) begin
                    state_nxt = CES_ST_PUSH_SR;
                end else if (take_exc || take_irq) begin
                    sr_copy_nxt = sr_r;
                    sr_nxt = sr_taken;
                    exc_nxt = take_irq ? CES_EXC_IRQ : exc_type_i;
                    trap_nxt = trap_num_i;
                    fs_nxt = fault_status_i;
                    lvl_nxt = take_lvl;
                    // Faulting PC lets the handler return and retry
                    pc_nxt = cif.use_fault ? fault_pc_i :
                             next_pc_i;
                    state_nxt = take_irq ? CES_ST_INTERRUPT_ACK_CYCLE :
                                CES_ST_PUSH_PC;
                end
            end
            CES_ST_INTERRUPT_ACK_CYCLE: begin
                if (mem_ack_i) begin
                    vec_nxt = mem_dat_i[7:0];
                    state_nxt = CES_ST_PUSH_PC;
                end
            end
            CES_ST_PUSH_PC: begin
                if (mem_ack_i) begin
                    state_nxt = CES_ST_PUSH_FV;
                end
            end
            CES_ST_PUSH_FV: begin
                if (mem_ack_i) begin
                    ssp_nxt = cif.frame_lo;
                    state_nxt = CES_ST_FETCH_VEC;
                end
            end
            CES_ST_FETCH_VEC: begin
                if (mem_ack_i) begin
                    hpc_nxt = mem_dat_i;
                    state_nxt = CES_ST_FETCH_OP;
                end
            end
            CES_ST_FETCH_OP: begin
                // Done as soon as the opcode fetch is launched
                inhibit_nxt = 1'b1;
                state_nxt = CES_ST_IDLE;
            end
            CES_ST_PUSH_SR: begin
                if (mem_ack_i) begin
                    ssp_nxt = ssp_r - `CES_PUSH_BYTES;
                    sr_nxt = pushld_imm_i;
                    state_nxt = CES_ST_IDLE;
                end
            end
            default: state_nxt = CES_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= CES_ST_IDLE;
            exc_r <= CES_EXC_ACCESS;
            sr_r <= `CES_SR_RST;
            sr_copy_r <= `CES_SR_RST;
            ssp_r <= `CES_SSP_RST;
            vbr_r <= `CES_VBR_RST;
            pc_r <= 32'h00000000;
            hpc_r <= 32'h00000000;
            fs_r <= 4'h0;
            trap_r <= 4'h0;
            lvl_r <= 3'h0;
            vec_r <= 8'h00;
            inhibit_r <= 1'b0;
            nmi_r <= 1'b0;
            lvl7_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            exc_r <= exc_nxt;
            sr_r <= sr_nxt;
            sr_copy_r <= sr_copy_nxt;
            ssp_r <= ssp_nxt;
            vbr_r <= vbr_nxt;
            pc_r <= pc_nxt;
            hpc_r <= hpc_nxt;
            fs_r <= fs_nxt;
            trap_r <= trap_nxt;
            lvl_r <= lvl_nxt;
            vec_r <= vec_nxt;
            inhibit_r <= inhibit_nxt;
            nmi_r <= nmi_nxt;
            lvl7_prev_r <= (irq_level_i == `CES_IRQ_EDGE_LVL);
        end
    end

    // ***************************************************************
    // Memory port
    // ***************************************************************
    always_comb begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b0;
        mem_ack_space_o = 1'b0;
        mem_adr_o = 32'h00000000;
        mem_dat_o = 32'h00000000;
        case (state_r)
            CES_ST_INTERRUPT_ACK_CYCLE: begin
                mem_ack_space_o = 1'b1;
                mem_adr_o = `CES_INTERRUPT_ACK_CYCLE_BASE | {27'h0, lvl_r, 2'b00};
            end
            CES_ST_PUSH_PC: begin
                mem_we_o = 1'b1;
                mem_adr_o = cif.frame_lo + `CES_PUSH_BYTES;
                mem_dat_o = pc_r;
            end
            CES_ST_PUSH_FV: begin
                mem_we_o = 1'b1;
                mem_adr_o = cif.frame_lo;
                mem_dat_o = {cif.fv, sr_copy_r};
            end
            CES_ST_FETCH_VEC: mem_adr_o = cif.vec_addr;
            CES_ST_PUSH_SR: begin
                mem_we_o = 1'b1;
                mem_adr_o = ssp_r - `CES_PUSH_BYTES;
                mem_dat_o = {16'h0, sr_r};
            end
            default: mem_req_o = 1'b0;
        endcase
    end

    // ***************************************************************
    // Wishbone slave
    // ***************************************************************
    logic ack_r, ack_nxt;
    logic [31:0] rd_r, rd_nxt;

    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `CES_REG_STATUS: rd_nxt = {16'h0, sr_r};
            `CES_REG_SSP: rd_nxt = ssp_r;
            `CES_REG_VBR: rd_nxt = vbr_r;
            `CES_REG_STATE: rd_nxt = {16'h0, vec_r, 1'b0, lvl_r,
                                      1'b0, nmi_r, inhibit_r, !idle};
            `CES_REG_HPC: rd_nxt = hpc_r;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rd_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;
    assign busy_o = !idle;
    assign handler_go_o = (state_r == CES_ST_FETCH_OP);
    assign handler_pc_o = hpc_r;
    assign status_word_o = sr_r;
    assign ssp_o = ssp_r;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_vec_done;
        state_r == CES_ST_FETCH_VEC && mem_ack_i;
    endsequence
    sequence s_handler_entry;
        handler_go_o ##1 !busy_o;
    endsequence

    a_take_status:
    assert property ((take_exc || take_irq) |=> sr_r[`CES_SR_S] &&
                     !sr_r[`CES_SR_T] && sr_copy_r == $past(sr_r))
        else $error("status not updated on exception entry");
    a_irq_mask:
    assert property (take_irq |=> !sr_r[`CES_SR_M] &&
                     sr_r[`CES_SR_IHI:`CES_SR_ILO] == $past(take_lvl))
        else $error("interrupt mask not loaded");
    a_fault_no_ack:
    assert property (take_exc |=> state_r == CES_ST_PUSH_PC)
        else $error("fault went to acknowledge");
    a_ack_address:
    assert property (state_r == CES_ST_INTERRUPT_ACK_CYCLE |-> mem_ack_space_o &&
                     mem_adr_o[4:2] == lvl_r)
        else $error("acknowledge address wrong");
    a_frame_aligned:
    assert property (state_r == CES_ST_PUSH_FV &&
                     $past(state_r) == CES_ST_PUSH_PC |->
                     mem_adr_o[1:0] == 2'b00 &&
                     mem_adr_o + 32'h4 == $past(mem_adr_o))
        else $error("frame not aligned");
    a_vector_fetch:
    assert property (state_r == CES_ST_FETCH_VEC |-> mem_adr_o ==
                     (vbr_r + {22'h0, cif.vec, 2'b00}))
        else $error("vector address wrong");
    a_handler_end:
    assert property (s_vec_done |=> s_handler_entry)
        else $error("handler entry not timely");
    a_format_ssp:
    assert property (state_r == CES_ST_PUSH_FV && mem_ack_i |->
                     mem_dat_o[31:28] == `CES_FMT_BASE + {2'b00, ssp_r[1:0]}
                     ##1 ssp_r == {$past(ssp_r[31:2]), 2'b00} - 32'h8)
        else $error("format or stack pointer wrong");
    a_fs_zero:
    assert property (state_r == CES_ST_PUSH_FV && exc_r != CES_EXC_ACCESS
                     && exc_r != CES_EXC_ADDRESS |->
                     mem_dat_o[27:26] == 2'b00 && mem_dat_o[17:16] == 2'b00)
        else $error("fault status not zero");
    a_irq_inhibit:
    assert property (handler_go_o ##1 !instr_done_i |=> !take_irq)
        else $error("interrupt taken in first handler instruction");
endmodule

`default_nettype wire

// ---- test/ces_irq_ctrl_model.sv ----
/* Memory and interrupt controller model facing the sequencer.
   Assumes one clock; answers every request one cycle late. */
`timescale 1ns/10ps
`default_nettype none
module ces_irq_ctrl_model #(
    parameter logic [31:0] XM = 32'h0F000000,
    parameter logic [7:0] VEC = 8'h40
) (
    input wire logic clk_i, // Core clock
    input wire logic req_i, // Memory request
    input wire logic we_i, // Write
    input wire logic ack_space_i, // Acknowledge space
    input wire logic [31:0] adr_i, // Address
    input wire logic [31:0] dat_i, // Write data
    output logic [31:0] dat_o, // Read data
    output logic ack_o // Answer
);
    logic [31:0] wa_q[$];
    logic [31:0] wd_q[$];
    initial begin
        dat_o = 32'h0;
        ack_o = 1'b0;
    end
    always @(posedge clk_i) begin
        if (req_i && !ack_o) begin
            ack_o <= 1'b1;
            if (we_i) begin
                wa_q.push_back(adr_i);
                wd_q.push_back(dat_i);
            end
            if (ack_space_i)
                dat_o <= {24'h0, VEC};
            else
                dat_o <= adr_i ^ XM;
        end else begin
            ack_o <= 1'b0;
            // Released bus must not echo the old value
            dat_o <= ~dat_o;
        end
    end
endmodule
`default_nettype wire

// ---- test/cpu_exception_sequencer_tb.sv ----
/* Self-checking bench of the exception sequencer.
   Assumes the memory model answers each request. */
`timescale 1ns/10ps
`default_nettype none
module cpu_exception_sequencer_tb;
    import ces_pkg::*;
    localparam logic [31:0] XM = 32'h0F000000;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, exc_req = 0;
    logic idone = 0, pl_req = 0, busy, go, mreq, mwe, msp, mack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 0, rd, fpc = 32'h1234, npc = 32'h1238;
    logic [31:0] hpc, supervisor_stack_pointer, madr, mwd, mrd;
    logic [15:0] sr, pl_imm = 16'h2700;
    logic [3:0] fs = 4'h9, tn = 4'h0;
    logic [2:0] irq = 3'h0;
    ces_exc_t etype = CES_EXC_ADDRESS;
    int n_mismatch = 0, cmp_count = 0;
    ces_exception_seq dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .exc_req_i(exc_req), .exc_type_i(etype), .trap_num_i(tn),
        .fault_status_i(fs), .fault_pc_i(fpc), .next_pc_i(npc),
        .instr_done_i(idone), .irq_level_i(irq), .pushld_req_i(pl_req),
        .pushld_imm_i(pl_imm), .busy_o(busy), .handler_go_o(go),
        .handler_pc_o(hpc), .status_word_o(sr), .ssp_o(supervisor_stack_pointer),
        .mem_req_o(mreq), .mem_we_o(mwe), .mem_ack_space_o(msp),
        .mem_adr_o(madr), .mem_dat_o(mwd), .mem_dat_i(mrd),
        .mem_ack_i(mack));
    ces_irq_ctrl_model #(.XM(XM)) m_u (.clk_i(clk_i), .req_i(mreq),
        .we_i(mwe), .ack_space_i(msp), .adr_i(madr), .dat_i(mwd),
        .dat_o(mrd), .ack_o(mack));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 40) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        guard(n);
        r = rd;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_go;
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (go !== 1'b1 && n < 40);
        guard(n);
    endtask
    task automatic t_fault;
        logic [31:0] r;
        wb(1, 8'h20, 32'h5, r);
        wb(0, 8'h20, 0, r);
        check(r, 32'h0);
        wb(1, 8'h00, 32'h8000, r);
        wb(1, 8'h04, 32'h1003, r);
        wb(1, 8'h08, 32'h00312345, r);
        wb(0, 8'h08, 0, r);
        check(r, 32'h00300000);
        exc_req <= 1'b1;
        @(posedge clk_i);
        exc_req <= 1'b0;
        wait_go();
        check(hpc, 32'h0030000C ^ XM);
        check(m_u.wa_q[0], 32'hFFC);
        check(m_u.wd_q[0], fpc);
        check(m_u.wa_q[1], 32'hFF8);
        check(m_u.wd_q[1], 32'h780D8000);
        @(posedge clk_i);
        check(supervisor_stack_pointer, 32'hFF8);
        check({16'h0, sr}, 32'h2000);
        $display("fault test done");
    endtask
    task automatic t_irq;
        irq <= 3'h3;
        repeat (4) @(posedge clk_i);
        check({31'h0, busy}, 32'h0);
        idone <= 1'b1;
        @(posedge clk_i);
        idone <= 1'b0;
        wait_go();
        irq <= 3'h0;
        check(hpc, 32'h00300100 ^ XM);
        check(m_u.wa_q[2], 32'hFF4);
        check(m_u.wd_q[2], npc);
        check(m_u.wd_q[3], 32'h41002000);
        @(posedge clk_i);
        check({16'h0, sr}, 32'h2300);
        $display("interrupt test done");
    endtask
    task automatic t_pushld;
        int n = 0;
        pl_req <= 1'b1;
        @(posedge clk_i);
        pl_req <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 40);
        guard(n);
        @(posedge clk_i);
        check(m_u.wa_q[4], 32'hFEC);
        check(m_u.wd_q[4], 32'h2300);
        check({16'h0, sr}, 32'h2700);
        $display("push-load test done");
    endtask
    task automatic t_trap;
        etype <= CES_EXC_TRAP;
        tn <= 4'h5;
        exc_req <= 1'b1;
        @(posedge clk_i);
        exc_req <= 1'b0;
        wait_go();
        check(hpc, 32'h00300094 ^ XM);
        check(m_u.wa_q[5], 32'hFE8);
        check(m_u.wd_q[5], npc);
        check(m_u.wd_q[6], 32'h40942700);
        @(posedge clk_i);
        check(supervisor_stack_pointer, 32'hFE4);
        $display("trap test done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_fault();
        t_irq();
        t_pushld();
        t_trap();
        end_of_test();
    end
endmodule
`default_nettype wire
